// file: verilog/tx_path_defs.svh
`ifndef TX_PATH_DEFS_SVH
`define TX_PATH_DEFS_SVH
// Function
// RULE_01: Take one signed 16-bit word per sample period.
// RULE_02: 48-tap filter doubles rate, rejects images.
// RULE_03: Filter DC gain fixed near 0.664.
// RULE_04: Modulator makes unity-gain one-bit density stream.
// RULE_05: Word 32767 gives about 82 percent ones.
// RULE_06: Host keeps words within plus/minus 32767.
// RULE_07: Output amplitude linear in transmit word.
// RULE_08: Phase clock generator fed twice converter rate.
// RULE_09: Front-end enable resets low, analog powered down.
// RULE_10: Tone boost raises reference 1.36V to 1.586V.
// RULE_11: Smoothing boost adds 1.65dB, multiplies with tone.
// RULE_12: Filter bandwidth scales with programmed sample rate.
// RULE_13: Software writes PLL reset register 0Dh last.
// RULE_14: Interpolator saturates output, never wraps.

// Interpolation filter shape
`define INTERP_TAPS        48
`define INTERP_PHASE_TAPS  24
// DC gain 0.6640625 over the polyphase branch sum of 300, in Q24
`define INTERP_SCALE_Q24   37137
`define INTERP_SCALE_SHIFT 24
// Modulator feedback level: a full-scale host word leaves the filter
// as 21759, and 21759 / 33998 = 0.64 -> 82 percent ones
`define MOD_FULL_SCALE     33998
// Modulator steps per interpolated word (96 for 3.072MHz at 16kHz)
`define MOD_HALF_STEPS  96
// Sample limits
`define WORD_MAX        16'h7FFF
`define WORD_MIN        16'h8000
`endif

// file: verilog/tx_path_pkg.sv
package tx_path_pkg;
  // Interpolator sequencing
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_SCALE
  } interp_state_type;
endpackage

// file: verilog/tx_history_mem.sv
`timescale 1ns/1ns
module tx_history_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 24,
  parameter int AW    = 5
) (
  // Clock
  input  wire logic             i_sys_clk,
  // Write port
  input  wire logic             i_wr_en,
  input  wire logic [AW-1:0]    i_wr_addr,
  input  wire logic [WIDTH-1:0] i_wr_data,
  // Registered read port
  input  wire logic [AW-1:0]    i_rd_addr,
  output logic      [WIDTH-1:0] o_rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Sample history; contents need no reset, the filter warms up
  always_ff @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end
endmodule

// file: verilog/tx_interp_sigma_delta_path.sv
`timescale 1ns/1ns
`include "tx_path_defs.svh"
module tx_interp_sigma_delta_path
  import tx_path_pkg::*;
#(
  parameter int TAPS       = `INTERP_TAPS,
  parameter int PTAPS      = `INTERP_PHASE_TAPS,
  parameter int HALF_STEPS = `MOD_HALF_STEPS
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // Transmit words from the host serial port
  input  wire logic [15:0] i_serial_data_in_word,
  input  wire logic        i_serial_data_in_valid,
  output logic             o_serial_data_in_ready,
  // Phase tick from the clock synthesis, two per modulator step
  input  wire logic        i_phase_tick,
  // Front-end controls
  input  wire logic        i_front_end_enable,
  input  wire logic        i_tone_level_boost,
  input  wire logic        i_smoothing_gain_boost,
  // To the analog section
  output logic             o_analog_phase_clock_gen,
  output logic             o_one_bit_converter,
  output logic             o_bit_strobe,
  output logic             o_bias_enable,
  output logic             o_tone_level_boost,
  output logic             o_smoothing_gain_boost
);
  localparam int AW = 5;
  localparam int CW = 7;
  localparam int AC = 26;
  localparam int IW = 26;
  localparam logic signed [47:0] SCALE = 48'(`INTERP_SCALE_Q24);
  localparam logic signed [IW-1:0] FS = IW'(`MOD_FULL_SCALE);

  // Triangular window: box of 24 convolved with a box of 25, sinc squared
  // image rejection; each polyphase branch sums to 300
  function automatic logic [CW-1:0] tap_coef(input int i);
    tap_coef = (i < TAPS / 2) ? CW'(i + 1) : CW'(TAPS - i);
  endfunction

  // Clamp to the signed 16-bit range instead of wrapping
  function automatic logic [15:0] sat16(input logic signed [23:0] v);
    if (v > 24'sh007FFF) begin
      sat16 = `WORD_MAX;
    end else if (v < -24'sh008000) begin
      sat16 = `WORD_MIN;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // Slot k places behind the write pointer; the pointer already names
  // the next free slot, so k = 1 is the newest word, k = 24 the oldest
  function automatic logic [AW-1:0] hist_idx(input logic [AW-1:0] newest,
                                             input logic [AW-1:0] k);
    hist_idx = (newest >= k) ? AW'(newest - k) : AW'(newest + PTAPS - k);
  endfunction

  interp_state_type            state;
  logic                        enable;
  logic [AW-1:0]               wptr;
  logic [AW-1:0]               k;
  logic [AW-1:0]               k_d;
  logic [AW-1:0]               fill;
  logic                        rd_valid;
  logic [15:0]                 rd_data;
  logic signed [AC-1:0]        acc_even;
  logic signed [AC-1:0]        acc_odd;
  logic [15:0]                 word_second;
  logic [15:0]                 mod_word;
  logic                        second_pending;
  logic [7:0]                  step_cnt;
  logic                        phase_div;
  logic signed [IW-1:0]        integ1;
  logic signed [IW-1:0]        integ2;
  logic                        mod_bit;

  // Handshake and sequencing decode
  wire accept   = i_serial_data_in_valid && o_serial_data_in_ready;
  wire issue    = (state == ST_RUN) && (k < AW'(PTAPS));
  wire last_tap = rd_valid && (k_d == AW'(PTAPS - 1));
  wire mod_step = enable && i_phase_tick && phase_div;
  wire logic [AW-1:0] rd_addr = hist_idx(wptr, AW'(k + 1'b1)); // [RULE_02]

  // Filter accepts only while idle and powered, so the host stalls
  assign o_serial_data_in_ready = enable && (state == ST_IDLE); // [RULE_01]

  // Slots never written read as zero, so power-up garbage in the
  // history cannot lock the modulator integrators
  wire logic                 tap_live = (k_d < fill);
  wire logic [15:0]          tap_data = tap_live ? rd_data : 16'h0000;

  // Polyphase products: even taps form the first output, odd the second
  wire logic signed [CW:0]   c_even = $signed({1'b0, tap_coef(2 * k_d)});
  wire logic signed [CW:0]   c_odd  = $signed({1'b0, tap_coef(2 * k_d + 1)});
  wire logic signed [23:0]   p_even = c_even * $signed(tap_data);
  wire logic signed [23:0]   p_odd  = c_odd * $signed(tap_data);
  wire logic signed [AC-1:0] sum_even = acc_even + AC'(p_even);
  wire logic signed [AC-1:0] sum_odd  = acc_odd + AC'(p_odd);

  // DC gain scaling, arithmetic shift by taking the top bits
  wire logic signed [47:0] scl_even = 48'(acc_even) * SCALE; // [RULE_03]
  wire logic signed [47:0] scl_odd  = 48'(acc_odd) * SCALE;  // [RULE_03]

  // Modulator loop: second order, feedback at +/- full scale
  wire logic signed [IW-1:0] fb = mod_bit ? FS : -FS;
  wire logic signed [IW-1:0] x_in = IW'($signed(mod_word));
  wire logic signed [IW-1:0] next_integ1 = integ1 + x_in - fb; // [RULE_04]
  wire logic signed [IW-1:0] next_integ2 = integ2 + next_integ1 - fb;

  tx_history_mem #(
    .WIDTH (16),
    .DEPTH (PTAPS),
    .AW    (AW)
  ) u_hist (
    .i_sys_clk (i_sys_clk),
    .i_wr_en   (accept),
    .i_wr_addr (wptr),
    .i_wr_data (i_serial_data_in_word),
    .i_rd_addr (rd_addr),
    .o_rd_data (rd_data)
  );

  // Front-end controls; enable powers bias and reference when high
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      enable                 <= 1'b0; // [RULE_09]
      o_bias_enable          <= 1'b0; // [RULE_09]
      o_tone_level_boost     <= 1'b0;
      o_smoothing_gain_boost <= 1'b0;
    end else begin
      enable                 <= i_front_end_enable;
      o_bias_enable          <= i_front_end_enable; // [RULE_09]
      // Selects the higher reference; meant for tone signalling only
      o_tone_level_boost     <= i_tone_level_boost; // [RULE_10]
      // Independent of the tone boost, so the two gains multiply
      o_smoothing_gain_boost <= i_smoothing_gain_boost; // [RULE_11]
    end
  end

  // Write pointer moves after each accepted word
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wptr <= '0;
    end else if (accept) begin
      wptr <= (wptr == AW'(PTAPS - 1)) ? '0 : AW'(wptr + 1'b1);
    end
  end

  // Words held so far, saturating at the history depth
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      fill <= '0;
    end else if (accept && (fill != AW'(PTAPS))) begin
      fill <= AW'(fill + 1'b1);
    end
  end

  // Interpolator sequence: 24 reads, then scale and saturate
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !enable) begin
      state    <= ST_IDLE;
      k        <= '0;
      k_d      <= '0;
      rd_valid <= 1'b0;
      acc_even <= '0;
      acc_odd  <= '0;
    end else begin
      rd_valid <= issue;
      k_d      <= k;
      unique case (state)
        ST_IDLE: begin
          k        <= '0;
          acc_even <= '0;
          acc_odd  <= '0;
          if (accept) begin
            state <= ST_RUN; // [RULE_01]
          end
        end
        ST_RUN: begin
          if (issue) begin
            k <= AW'(k + 1'b1);
          end
          if (rd_valid) begin
            acc_even <= sum_even; // [RULE_02]
            acc_odd  <= sum_odd;  // [RULE_02]
          end
          if (last_tap) begin
            state <= ST_SCALE;
          end
        end
        ST_SCALE: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Two words per input; the second is held for the second half period.
  // All timing follows the phase tick, so bandwidth tracks Fs.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !enable) begin
      mod_word       <= '0;
      word_second    <= '0;
      second_pending <= 1'b0;
      step_cnt       <= '0;
    end else if (state == ST_SCALE) begin
      mod_word       <= sat16(scl_even[47:24]); // [RULE_14] [RULE_02]
      word_second    <= sat16(scl_odd[47:24]);  // [RULE_14]
      second_pending <= 1'b1;
      step_cnt       <= '0;
    end else if (mod_step) begin
      if (second_pending && step_cnt == 8'(HALF_STEPS - 1)) begin
        mod_word       <= word_second; // [RULE_02] [RULE_12]
        second_pending <= 1'b0;
        step_cnt       <= '0;
      end else begin
        step_cnt <= 8'(step_cnt + 1'b1);
      end
    end
  end

  // Phase clock strobe runs at twice the modulator rate
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !enable) begin
      phase_div                <= 1'b0;
      o_analog_phase_clock_gen <= 1'b0;
    end else begin
      o_analog_phase_clock_gen <= i_phase_tick; // [RULE_08]
      if (i_phase_tick) begin
        phase_div <= ~phase_div; // [RULE_08]
      end
    end
  end

  // Modulator: linear in the word, density (1 + x / full scale) / 2
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !enable) begin
      integ1       <= '0;
      integ2       <= '0;
      mod_bit      <= 1'b0;
      o_bit_strobe <= 1'b0;
    end else begin
      o_bit_strobe <= mod_step;
      if (mod_step) begin
        integ1  <= next_integ1;          // [RULE_07]
        integ2  <= next_integ2;
        mod_bit <= ~next_integ2[IW-1];   // [RULE_04] [RULE_05]
      end
    end
  end

  assign o_one_bit_converter = mod_bit;
endmodule

// file: verif/tx_path_properties.sv
`timescale 1ns/1ns
module tx_path_checker (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Inputs watched
  input wire logic i_serial_data_in_valid,
  input wire logic i_phase_tick,
  input wire logic i_front_end_enable,
  input wire logic i_tone_level_boost,
  input wire logic i_smoothing_gain_boost,
  // Outputs watched
  input wire logic o_serial_data_in_ready,
  input wire logic o_analog_phase_clock_gen,
  input wire logic o_one_bit_converter,
  input wire logic o_bit_strobe,
  input wire logic o_bias_enable,
  input wire logic o_tone_level_boost,
  input wire logic o_smoothing_gain_boost
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // Enable is registered straight through to the analog bias
  chk_bias_follows:
    assert property (i_front_end_enable |=> o_bias_enable)
    else $error("bias enable did not follow front-end enable");
  chk_ready_off:
    assert property (!o_bias_enable |-> !o_serial_data_in_ready)
    else $error("ready while front end disabled");
  // A taken word keeps the filter busy, but only for a bounded time
  chk_take_busy:
    assert property (i_serial_data_in_valid && o_serial_data_in_ready
      |=> !o_serial_data_in_ready [*8] ##[1:40] o_serial_data_in_ready)
    else $error("ready timing after a take is wrong");
  chk_strobe_pulse:
    assert property (o_bit_strobe |=> !o_bit_strobe)
    else $error("bit strobe longer than one cycle");
  chk_strobe_phase:
    assert property (o_bit_strobe |-> o_analog_phase_clock_gen)
    else $error("modulator step without a phase pulse");
  chk_phase_gen:
    assert property (i_phase_tick && i_front_end_enable
      && o_bias_enable |=> o_analog_phase_clock_gen)
    else $error("phase tick not passed to clock generator");
  chk_phase_idle:
    assert property (!i_phase_tick |=> !o_analog_phase_clock_gen)
    else $error("phase pulse without a tick");
  // The modulator bit may only move on a step
  chk_bit_hold:
    assert property (o_bias_enable && !o_bit_strobe
      |-> $stable(o_one_bit_converter))
    else $error("modulator bit changed without a step");
  chk_tone_copy:
    assert property (1 |=> o_tone_level_boost
      == $past(i_tone_level_boost))
    else $error("tone boost not copied");
  chk_smooth_copy:
    assert property (1 |=> o_smoothing_gain_boost
      == $past(i_smoothing_gain_boost))
    else $error("smoothing boost not copied");
endmodule
bind tx_interp_sigma_delta_path tx_path_checker tx_path_checker_i (
  .i_sys_clk, .i_rst_n, .i_serial_data_in_valid, .i_phase_tick,
  .i_front_end_enable, .i_tone_level_boost, .i_smoothing_gain_boost,
  .o_serial_data_in_ready, .o_analog_phase_clock_gen, .o_one_bit_converter,
  .o_bit_strobe, .o_bias_enable, .o_tone_level_boost,
  .o_smoothing_gain_boost);

// file: verif/tx_host_port_model.sv
`timescale 1ns/1ns
module tx_host_port_model #(
  parameter int FS_CYC = 64
) (
  // Clock, reset, control
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_run,
  input  wire logic [15:0] i_word,
  // Handshake with the transmit path
  input  wire logic        i_ready,
  output logic      [15:0] o_word,
  output logic             o_valid
);
  int   cnt;
  logic taken;
  // Offer one word per sample period and hold it until taken
  always @(negedge i_sys_clk) begin
    if (!i_rst_n || !i_run) begin
      o_valid <= 1'b0;
      cnt     <= 0;
    end else begin
      cnt <= (cnt == FS_CYC - 1) ? 0 : cnt + 1;
      if (cnt == 0) begin
        o_valid <= 1'b1;
        o_word  <= i_word;
      end else if (taken) begin
        o_valid <= 1'b0;
        o_word  <= ~o_word; // Released lines must not look valid
      end
    end
  end
  always @(posedge i_sys_clk) taken <= o_valid && i_ready;
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam int HS = 8;
  localparam int FS_CYC = HS * 8; // Two words of HS steps, 4 cycles a step
  logic i_sys_clk = 0, i_rst_n = 0, tick = 0, en = 0, tone = 0, smo = 0;
  logic run = 0, valid, ready, pclk, bit_o, strobe, bias, o_tone, o_smo;
  logic [15:0] tx_word = 16'h0000, word;
  int num_errors = 0, check_count = 0, dfull, dh, dz, dn;
  always #50 i_sys_clk = ~i_sys_clk;
  // Ticks two cycles apart, so a modulator step every fourth cycle
  // Synthesis settings stay fixed here, so no sequence-reset write
  always @(negedge i_sys_clk) tick <= i_rst_n & ~tick;
  tx_interp_sigma_delta_path #(.HALF_STEPS(HS)) tx_interp_sigma_delta_path_i (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_serial_data_in_word(word),
    .i_serial_data_in_valid(valid), .o_serial_data_in_ready(ready),
    .i_phase_tick(tick), .i_front_end_enable(en), .i_tone_level_boost(tone),
    .i_smoothing_gain_boost(smo), .o_analog_phase_clock_gen(pclk),
    .o_one_bit_converter(bit_o), .o_bit_strobe(strobe), .o_bias_enable(bias),
    .o_tone_level_boost(o_tone), .o_smoothing_gain_boost(o_smo));
  tx_host_port_model #(.FS_CYC(FS_CYC)) tx_host_port_model_i (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_run(run), .i_word(tx_word),
    .i_ready(ready), .o_word(word), .o_valid(valid));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  // Boost bits pass through; enable brings up bias and ready
  task automatic t_ctrl;
    chk({ready, bias, bit_o, strobe, pclk, o_tone, o_smo}, 0);
    for (int i = 0; i < 4; i++) begin
      {tone, smo} = i[1:0];
      cyc(2);
      chk(o_tone, i[1]);
      chk(o_smo, i[0]);
    end
    chk(ready, 0);
    en = 1;
    for (int i = 0; i < 6 && !ready; i++) cyc(1);
    chk(bias, 1);
    if (ready !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
  endtask
  // Steady word in, ones density out, in per mille
  task automatic measure(input logic [15:0] w, output int d);
    int ones, steps, ph;
    ones = 0;
    steps = 0;
    ph = 0;
    tx_word = w;
    run = 1;
    cyc(30 * FS_CYC);
    repeat (16 * FS_CYC) begin
      cyc(1);
      ph += pclk;
      steps += strobe;
      ones += strobe & bit_o;
    end
    chk(steps, 4 * FS_CYC);
    chk(ph, 2 * steps);
    d = ones * 1000 / (steps > 0 ? steps : 1);
  endtask
  // Density checks: full scale, half scale, zero, negative full scale
  task automatic t_levels;
    measure(16'h7FFF, dfull);
    chk(dfull inside {[760:880]}, 1);
    measure(16'h4000, dh);
    chk((2 * dh - dfull - 500) inside {[-40:40]}, 1);
    measure(16'h0000, dz);
    chk(dz inside {[470:530]}, 1);
    measure(16'h8001, dn);
    chk((dn + dfull) inside {[960:1040]}, 1);
  endtask
  // Dropping enable powers down and silences the analog clocks
  task automatic t_disable;
    int ph;
    ph = 0;
    run = 0;
    cyc(FS_CYC);
    en = 0;
    cyc(3);
    chk({bias, ready, bit_o, strobe}, 0);
    repeat (16) begin
      cyc(1);
      ph += pclk;
    end
    chk(ph, 0);
  endtask
  initial begin
    cyc(20);
    i_rst_n = 1;
    t_ctrl();
    t_levels();
    t_disable();
    end_of_test();
  end
endmodule
